// ### dv/testbench.sv
// Self-checking bench for the serial status-flag and bit-rate block.
`timescale 1ns/100ps
module testbench;
	import usfbg_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic       bus_wr = 1'b0;
	logic       bus_rd = 1'b0;
	logic       test_mode = 1'b0;
	logic       stop_mode = 1'b0;
	logic       receiver_enable = 1'b1;
	logic       receiver_sleep = 1'b0;
	logic       nine_bit_mode = 1'b0;
	logic [7:0] bus_rdata, serial_status_flags, tx_data, rx_byte;
	logic       tx_data_write, rx_buffer_load, rx_sample_tick, baud_tick;
	logic       tx_pin_test_en, tx_pin_test_value, tx_xfer, tx_idle, rx_byte_ready;
	logic       rx_stop_bit, rx_frame_start, rx_noise_event, rx_bit_done, rx_bit_value;
	int         error_cnt = 0;
	int         n_compared = 0;
	usfbg_top i_usfbg_top (.*);
	usfbg_peer i_usfbg_peer (.*);
	always #5 core_clk = ~core_clk;
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt++;
		conclude();
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	// Status read then data read: the clearing order for every receive flag.
	task automatic clear();
		logic [7:0] v;
		rd(ADDR_STATUS, v);
		rd(ADDR_DATA, v);
	endtask
	task automatic gap(input bit b, output logic [7:0] n);
		n = 8'h00;
		do @(negedge core_clk); while (!(b ? baud_tick : rx_sample_tick));
		do begin
			@(negedge core_clk);
			n++;
		end while (!(b ? baud_tick : rx_sample_tick));
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	initial begin
		logic [7:0] v;
		logic [7:0] cfg [5] = '{8'h07, 8'h00, 8'h10, 8'h20, 8'h30};
		logic [7:0] ex [5] = '{8'h80, 8'h01, 8'h03, 8'h04, 8'h0D};
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdchk(ADDR_BAUD, BAUD_RESET);
		rdchk(8'h50, READ_ZERO);
		wr(ADDR_DATA, 8'h11);
		@(negedge core_clk);
		chk(8'(tx_data_write), 8'h00);
		rdchk(ADDR_STATUS, STATUS_RESET);
		wr(ADDR_STATUS, 8'hFF);
		rdchk(ADDR_STATUS, STATUS_RESET);
		wr(ADDR_DATA, 8'h5A);
		@(negedge core_clk);
		chk(8'(tx_data_write), 8'h01);
		rdchk(ADDR_STATUS, 8'h00);
		chk(tx_data, 8'h5A);
		wr(ADDR_DATA, 8'hA5);
		@(negedge core_clk);
		chk(tx_data, 8'hA5);
		chk(8'(tx_data_write), 8'h01);
		i_usfbg_peer.xfer(1'b1, 1'b0);
		rdchk(ADDR_STATUS, 8'h80);
		i_usfbg_peer.xfer(1'b0, 1'b1);
		rdchk(ADDR_STATUS, 8'hC0);
		done("transmit");
		i_usfbg_peer.ones(9);
		rdchk(ADDR_STATUS, 8'hC0);
		i_usfbg_peer.ones(1);
		rdchk(ADDR_STATUS, 8'hD0);
		clear();
		rdchk(ADDR_STATUS, 8'hC0);
		i_usfbg_peer.zero();
		i_usfbg_peer.ones(11);
		rdchk(ADDR_STATUS, 8'hC0);
		i_usfbg_peer.frame(8'h3C, 1'b1, 1'b0);
		rdchk(ADDR_STATUS, 8'hE0);
		i_usfbg_peer.frame(8'h77, 1'b1, 1'b0);
		rdchk(ADDR_STATUS, 8'hE8);
		clear();
		rdchk(ADDR_STATUS, 8'hC0);
		i_usfbg_peer.frame(8'h81, 1'b0, 1'b1);
		rdchk(ADDR_STATUS, 8'hE6);
		i_usfbg_peer.frame(8'h99, 1'b1, 1'b0);
		rdchk(ADDR_STATUS, 8'hEE);
		clear();
		rdchk(ADDR_STATUS, 8'hC0);
		@(posedge core_clk) nine_bit_mode <= 1'b1;
		i_usfbg_peer.ones(10);
		rdchk(ADDR_STATUS, 8'hC0);
		i_usfbg_peer.ones(1);
		rdchk(ADDR_STATUS, 8'hD0);
		clear();
		@(posedge core_clk) nine_bit_mode <= 1'b0;
		i_usfbg_peer.frame(8'h42, 1'b1, 1'b0);
		@(posedge core_clk) receiver_sleep <= 1'b1;
		i_usfbg_peer.frame(8'h24, 1'b0, 1'b1);
		rdchk(ADDR_STATUS, 8'hE0);
		@(posedge core_clk) receiver_sleep <= 1'b0;
		@(posedge core_clk) receiver_enable <= 1'b0;
		rdchk(ADDR_STATUS, 8'hC0);
		@(posedge core_clk) receiver_enable <= 1'b1;
		clear();
		done("receive");
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_BAUD, cfg[i]);
			gap(1'b0, v);
			gap(1'b0, v);
			chk(v, ex[i]);
		end
		gap(1'b1, v);
		gap(1'b1, v);
		chk(v, 8'hD0);
		// The port is idle here, so halting loses no traffic.
		@(posedge core_clk) stop_mode <= 1'b1;
		v = 8'h00;
		repeat (40) @(negedge core_clk) v += 8'(rx_sample_tick);
		chk(v, 8'h00);
		@(posedge core_clk) stop_mode <= 1'b0;
		gap(1'b0, v);
		chk(v, 8'h0D);
		wr(ADDR_BAUD, 8'h88);
		rdchk(ADDR_BAUD, 8'h00);
		chk(8'(tx_pin_test_en), 8'h00);
		@(posedge core_clk) test_mode <= 1'b1;
		wr(ADDR_BAUD, 8'h08);
		rdchk(ADDR_BAUD, 8'h00);
		@(negedge core_clk);
		chk(8'(tx_pin_test_en), 8'h01);
		v = 8'(tx_pin_test_value);
		@(negedge core_clk);
		chk(8'(tx_pin_test_value), v ^ 8'h01);
		wr(ADDR_BAUD, 8'h93);
		// After the clear the chains restart from zero, so the first tick lands on a fixed cycle.
		@(negedge core_clk);
		v = 8'h01;
		do begin
			@(negedge core_clk);
			v++;
		end while (!rx_sample_tick);
		chk(v, 8'h1A);
		rdchk(ADDR_BAUD, 8'h13);
		done("bit rate");
		conclude();
	end
endmodule

// ### dv/usfbg_checker_assertions.sv
// Port-level checks of the serial status-flag and bit-rate block.
`timescale 1ns/100ps
module usfbg_checker
	import usfbg_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic [7:0] bus_addr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       stop_mode,
	input wire logic       receiver_enable,
	input wire logic       receiver_sleep,
	input wire logic       tx_xfer,
	input wire logic       rx_byte_ready,
	input wire logic [7:0] serial_status_flags,
	input wire logic       rx_buffer_load,
	input wire logic       rx_sample_tick
);
	wire logic [7:0] f;
	wire logic       awake;
	assign f = serial_status_flags;
	assign awake = receiver_enable && !receiver_sleep;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_load;
		rx_buffer_load ##1 f[ST_RX_BUFFER_FULL];
	endsequence
	sequence s_overrun;
		!rx_buffer_load ##1 f[ST_OR];
	endsequence
	property p_status_rd;
		$past(bus_rd) && $past(bus_addr) == ADDR_STATUS |-> bus_rdata == $past(f);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read mismatch");
	property p_test_ro;
		bus_rd && bus_addr == ADDR_BAUD |=> !bus_rdata[BD_DIVIDER_CLEAR_TEST] && !bus_rdata[BD_RX_CLOCK_TEST];
	endproperty
	a_test_ro: assert property (p_test_ro) else $error("test bit read as one");
	property p_tx_buffer_empty;
		tx_xfer && !receiver_sleep |=> f[ST_TX_BUFFER_EMPTY];
	endproperty
	a_tx_buffer_empty: assert property (p_tx_buffer_empty) else $error("transmit empty not set");
	property p_load;
		rx_byte_ready && !f[ST_RX_BUFFER_FULL] && !f[ST_FE] && awake |-> s_load;
	endproperty
	a_load: assert property (p_load) else $error("byte not loaded");
	property p_overrun;
		rx_byte_ready && f[ST_RX_BUFFER_FULL] && awake |-> s_overrun;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
	property p_fe;
		$rose(f[ST_FE]) |-> $rose(f[ST_RX_BUFFER_FULL]);
	endproperty
	a_fe: assert property (p_fe) else $error("framing set without full");
	property p_sleep;
		receiver_sleep && $past(receiver_sleep) |-> (f[5:1] & ~$past(f[5:1])) == 5'h00;
	endproperty
	a_sleep: assert property (p_sleep) else $error("flag set while asleep");
	property p_stop;
		stop_mode |-> !rx_sample_tick;
	endproperty
	a_stop: assert property (p_stop) else $error("sample tick in stop");
endmodule
bind usfbg_top usfbg_checker i_usfbg_checker (.core_clk(core_clk), .rst_n(rst_n),
	.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_mode(stop_mode),
	.receiver_enable(receiver_enable), .receiver_sleep(receiver_sleep), .tx_xfer(tx_xfer),
	.rx_byte_ready(rx_byte_ready), .serial_status_flags(serial_status_flags),
	.rx_buffer_load(rx_buffer_load), .rx_sample_tick(rx_sample_tick));

// ### dv/usfbg_peer.sv
// Model of the serial datapath and far node that raise transfer and receive events.
`timescale 1ns/100ps
module usfbg_peer (
	input  wire logic       core_clk,
	output logic            tx_xfer,
	output logic            tx_idle,
	output logic            rx_byte_ready,
	output logic            rx_stop_bit,
	output logic            rx_frame_start,
	output logic            rx_noise_event,
	output logic            rx_bit_done,
	output logic            rx_bit_value,
	output logic      [7:0] rx_byte
);
	initial begin
		{tx_xfer, tx_idle, rx_byte_ready, rx_stop_bit, rx_frame_start} = 5'h00;
		{rx_noise_event, rx_bit_done, rx_bit_value} = 3'h0;
		rx_byte = 8'h00;
	end
	task automatic xfer(input logic v, input logic i);
		@(posedge core_clk);
		tx_xfer <= v;
		tx_idle <= i;
		@(posedge core_clk);
		tx_xfer <= 1'b0;
		tx_idle <= 1'b0;
	endtask
	// Noise is only reported after a valid start, so idle noise never reaches the flag.
	task automatic frame(input logic [7:0] d, input logic sb, input logic nz);
		@(posedge core_clk);
		rx_frame_start <= 1'b1;
		rx_bit_done    <= 1'b1;
		rx_bit_value   <= 1'b0;
		@(posedge core_clk);
		rx_frame_start <= 1'b0;
		rx_bit_done    <= 1'b0;
		rx_noise_event <= nz;
		@(posedge core_clk);
		rx_noise_event <= 1'b0;
		rx_byte_ready  <= 1'b1;
		rx_stop_bit    <= sb;
		rx_byte        <= d;
		@(posedge core_clk);
		rx_byte_ready  <= 1'b0;
		rx_stop_bit    <= ~sb;
	endtask
	// A single zero bit restarts the count of consecutive ones.
	task automatic zero();
		@(posedge core_clk);
		rx_bit_done  <= 1'b1;
		rx_bit_value <= 1'b0;
		@(posedge core_clk);
		rx_bit_done  <= 1'b0;
	endtask
	task automatic ones(input int n);
		repeat (n) begin
			@(posedge core_clk);
			rx_bit_done  <= 1'b1;
			rx_bit_value <= 1'b1;
		end
		@(posedge core_clk);
		rx_bit_done  <= 1'b0;
		rx_bit_value <= 1'b0;
	endtask
endmodule

// ### hdl/usfbg_baud_div.sv
// Two-stage bit-rate divider producing the 16x sample tick and the bit tick.
`timescale 1ns/100ps
module usfbg_baud_div (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       halt,
	input  wire logic [1:0] first_stage_ratio_sel,
	input  wire logic [2:0] second_stage_ratio_sel,
	output logic            sample_tick,
	output logic            bit_tick
);
	import usfbg_pkg::*;

	logic [3:0]            pre_cnt;
	logic [3:0]            next_pre_cnt;
	logic [SECOND_STAGE_RATIO_WIDTH-1:0] rate_cnt;
	logic [SECOND_STAGE_RATIO_WIDTH-1:0] next_rate_cnt;
	logic [3:0]            over_cnt;
	logic [3:0]            next_over_cnt;
	logic                  next_sample_tick;
	logic                  next_bit_tick;
	logic                  pre_tick;
	logic [SECOND_STAGE_RATIO_WIDTH-1:0] rate_mask;

	// Stage two is free running; a tick falls when the low field bits are all ones.
	always_comb begin
		rate_mask        = SECOND_STAGE_RATIO_WIDTH'((8'h01 << second_stage_ratio_sel) - 8'h01);
		pre_tick         = (pre_cnt >= usfbg_first_stage_ratio_last(first_stage_ratio_sel));
		next_pre_cnt     = pre_cnt;
		next_rate_cnt    = rate_cnt;
		next_over_cnt    = over_cnt;
		next_sample_tick = 1'b0;
		next_bit_tick    = 1'b0;
		if (clear) begin
			next_pre_cnt  = 4'h0;
			next_rate_cnt = '0;
			next_over_cnt = 4'h0;
		end else if (!halt) begin
			next_pre_cnt = pre_tick ? 4'h0 : pre_cnt + 4'h1; // [RQ15]
			if (pre_tick) begin
				next_rate_cnt = rate_cnt + SECOND_STAGE_RATIO_WIDTH'(1);
				if ((rate_cnt & rate_mask) == rate_mask) begin // [RQ16]
					next_sample_tick = 1'b1; // [RQ17]
					next_over_cnt    = over_cnt + 4'h1;
					next_bit_tick    = (over_cnt == OVERSAMPLE_LAST); // [RQ17]
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt     <= 4'h0;
			rate_cnt    <= '0;
			over_cnt    <= 4'h0;
			sample_tick <= 1'b0;
			bit_tick    <= 1'b0;
		end else begin
			pre_cnt     <= next_pre_cnt;
			rate_cnt    <= next_rate_cnt;
			over_cnt    <= next_over_cnt;
			sample_tick <= next_sample_tick;
			bit_tick    <= next_bit_tick;
		end
	end

endmodule

// ### hdl/usfbg_top.sv
// Status flags, clearing sequences and bit-rate generator of the serial port.
//
// Notes on behaviour
// [RQ1] Buffer-to-shifter move sets transmit-empty; while clear, a data write replaces the byte.
// [RQ2] Transmit-empty clears only on status read seeing it, then data write.
// [RQ3] Transmit-complete sets when nothing is left to send; never stalls transmitter.
// [RQ4] Transmit-complete clears on access seeing it set, then data write.
// [RQ5] Shifter-to-buffer move sets receive-full; status read then data read clears it.
// [RQ6] Ten ones, eleven in nine-bit format, set idle; never while asleep.
// [RQ7] After clearing, idle stays clear until receive-full sets again.
// [RQ8] Idle clears on status read seeing it, then data read.
// [RQ9] Byte arriving while receive-full set raises overrun and is discarded.
// [RQ10] Overrun clears on status read seeing it, then data read.
// [RQ11] Working noise flag copies into visible noise flag when byte is buffered.
// [RQ12] Noise has no interrupt; clears on status read then data read.
// [RQ13] Zero stop bit sets framing error with receive-full, not on overrun.
// [RQ14] Framing error blocks buffer loads; clears on status read then data read.
// [RQ15] First stage divides by 1, 3, 4 or 13.
// [RQ16] Second stage divides by two to the power of the rate field.
// [RQ17] Bit rate is clock over 16 and both ratios; sampling runs 16x.
// [RQ18] Counter-clear test bit resets dividers in test mode only, reads zero.
// [RQ19] Receive-clock test bit drives toggled 16x clock on transmit pin, reads zero.
// [RQ20] Stop state halts the generator; transmission resumes afterwards.
// [RQ21] Stop state during reception stops sampling; remaining bits are lost.
// [RQ22] Software should idle the port before entering the stop state.
// [RQ23] While asleep no receive flag sets and earlier flags stay unchanged.
// [RQ24] While the receiver is disabled all receiver flags are held clear.
// [RQ25] Status register is read-only; only events and sequences change it.
`timescale 1ns/100ps
module usfbg_top (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic       test_mode,
	input  wire logic       stop_mode,
	input  wire logic       receiver_enable,
	input  wire logic       receiver_sleep,
	input  wire logic       nine_bit_mode,
	input  wire logic       tx_xfer,
	input  wire logic       tx_idle,
	input  wire logic       rx_byte_ready,
	input  wire logic       rx_stop_bit,
	input  wire logic       rx_frame_start,
	input  wire logic       rx_noise_event,
	input  wire logic       rx_bit_done,
	input  wire logic       rx_bit_value,
	input  wire logic [7:0] rx_byte,
	output logic      [7:0] serial_status_flags,
	output logic      [7:0] tx_data,
	output logic            tx_data_write,
	output logic            rx_buffer_load,
	output logic            rx_sample_tick,
	output logic            baud_tick,
	output logic            tx_pin_test_en,
	output logic            tx_pin_test_value
);
	import usfbg_pkg::*;

	// Reset release synchroniser.
	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Bus decode.
	logic wr_data;
	logic wr_baud;
	logic rd_data;
	logic rd_status;

	assign wr_data   = bus_wr && (bus_addr == ADDR_DATA);
	assign wr_baud   = bus_wr && (bus_addr == ADDR_BAUD);
	assign rd_data   = bus_rd && (bus_addr == ADDR_DATA);
	assign rd_status = bus_rd && (bus_addr == ADDR_STATUS);

	// Baud register and test controls.
	logic [1:0]   first_stage_ratio_sel;
	logic [2:0]   second_stage_ratio_sel;
	logic         rx_clock_test;
	logic         divider_clear_test;
	logic [1:0]   next_first_stage_ratio_sel;
	logic [2:0]   next_second_stage_ratio_sel;
	logic         next_rx_clock_test;
	logic         next_divider_clear_test;
	logic         rx_clk_phase;
	logic         next_rx_clk_phase;
	usfbg_power_t power;
	usfbg_power_t next_power;
	logic         div_sample_tick;
	logic         div_bit_tick;
	logic         running;

	always_comb begin
		next_first_stage_ratio_sel           = first_stage_ratio_sel;
		next_second_stage_ratio_sel           = second_stage_ratio_sel;
		next_rx_clock_test      = rx_clock_test && test_mode; // [RQ19]
		next_divider_clear_test = 1'b0;
		if (wr_baud) begin
			next_first_stage_ratio_sel = bus_wdata[BD_SCP_HI:BD_SCP_LO];
			next_second_stage_ratio_sel = bus_wdata[BD_SCR_HI:BD_SCR_LO];
			// The clear bit is transitory: it lives one cycle and never reads back.
			next_divider_clear_test = bus_wdata[BD_DIVIDER_CLEAR_TEST] && test_mode; // [RQ18]
			next_rx_clock_test      = bus_wdata[BD_RX_CLOCK_TEST] && test_mode; // [RQ19]
		end
		next_power = stop_mode ? USFBG_STOP : USFBG_RUN;
		next_rx_clk_phase = rx_clk_phase ^ div_sample_tick; // [RQ19]
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			first_stage_ratio_sel           <= BAUD_RESET[BD_SCP_HI:BD_SCP_LO];
			second_stage_ratio_sel           <= BAUD_RESET[BD_SCR_HI:BD_SCR_LO];
			rx_clock_test      <= 1'b0;
			divider_clear_test <= 1'b0;
			rx_clk_phase       <= 1'b0;
			power              <= USFBG_RUN;
		end else begin
			first_stage_ratio_sel           <= next_first_stage_ratio_sel;
			second_stage_ratio_sel           <= next_second_stage_ratio_sel;
			rx_clock_test      <= next_rx_clock_test;
			divider_clear_test <= next_divider_clear_test;
			rx_clk_phase       <= next_rx_clk_phase;
			power              <= next_power;
		end
	end

	// Halting the divider freezes every tick, so sampling of a frame in flight stops.
	usfbg_baud_div u_baud_div (
		.core_clk    (core_clk),
		.rst_n       (rst_sync_n),
		.clear       (divider_clear_test), // [RQ18]
		.halt        (!running), // [RQ20]
		.first_stage_ratio_sel    (first_stage_ratio_sel),
		.second_stage_ratio_sel    (second_stage_ratio_sel),
		.sample_tick (div_sample_tick),
		.bit_tick    (div_bit_tick)
	);

	// Stop takes hold in the very cycle it is asked for, so no stale tick slips out.
	assign running           = (power == USFBG_RUN) && (next_power == USFBG_RUN); // [RQ20]
	// No tick leaves during stop, so sampling ends and the rest of a character is lost.
	assign rx_sample_tick    = div_sample_tick && running; // [RQ21]
	assign baud_tick         = div_bit_tick && running; // [RQ20]
	assign tx_pin_test_en    = rx_clock_test; // [RQ19]
	assign tx_pin_test_value = rx_clk_phase; // [RQ19]

	// Transmit buffer.
	logic [7:0] next_tx_data;
	logic       tx_accept;

	always_comb begin
		next_tx_data = tx_data;
		if (wr_data) begin
			next_tx_data = bus_wdata; // [RQ1]
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tx_data       <= 8'h00;
			tx_data_write <= 1'b0;
		end else begin
			tx_data       <= next_tx_data;
			tx_data_write <= wr_data && tx_accept; // [RQ2]
		end
	end

	// Status flags and their clearing sequences.
	logic [7:0] flags;
	logic [7:0] next_flags;
	logic [7:0] armed;
	logic [7:0] next_armed;
	logic       work_noise;
	logic       next_work_noise;
	logic       idle_allowed;
	logic       next_idle_allowed;
	logic [3:0] ones_cnt;
	logic [3:0] next_ones_cnt;
	logic [3:0] ones_limit;
	logic       rx_active;
	logic       rx_blocked;
	logic       idle_hit;

	assign ones_limit = nine_bit_mode ? IDLE_ONES_9BIT : IDLE_ONES_8BIT; // [RQ6]
	assign rx_active  = receiver_enable && !receiver_sleep; // [RQ23] [RQ24]
	// A framing error or full buffer stops the load.
	assign rx_blocked = flags[ST_RX_BUFFER_FULL] || flags[ST_FE]; // [RQ9] [RQ14]
	assign rx_buffer_load = rx_byte_ready && rx_active && !rx_blocked; // [RQ5]
	assign idle_hit = rx_bit_done && rx_bit_value && (ones_cnt == ones_limit - 4'h1);

	always_comb begin
		next_flags        = flags;
		next_armed        = armed;
		next_work_noise   = work_noise;
		next_idle_allowed = idle_allowed;
		next_ones_cnt     = ones_cnt;

		// Clears first, so that a set in the same cycle wins.
		if (wr_data) begin
			if (armed[ST_TX_BUFFER_EMPTY]) begin
				next_flags[ST_TX_BUFFER_EMPTY] = 1'b0; // [RQ2]
			end
			if (armed[ST_TC]) begin
				next_flags[ST_TC] = 1'b0; // [RQ4]
			end
			next_armed[ST_TX_BUFFER_EMPTY] = 1'b0;
			next_armed[ST_TC]   = 1'b0;
		end
		if (rd_data) begin
			if (armed[ST_RX_BUFFER_FULL]) begin
				next_flags[ST_RX_BUFFER_FULL] = 1'b0; // [RQ5]
			end
			if (armed[ST_IDLE]) begin
				next_flags[ST_IDLE] = 1'b0; // [RQ8]
			end
			if (armed[ST_OR]) begin
				next_flags[ST_OR] = 1'b0; // [RQ10]
			end
			if (armed[ST_NF]) begin
				next_flags[ST_NF] = 1'b0; // [RQ12]
			end
			if (armed[ST_FE]) begin
				next_flags[ST_FE] = 1'b0; // [RQ14]
			end
			next_armed[ST_RX_BUFFER_FULL:ST_FE] = 5'h00;
		end
		// A status read arms each flag it sees set for the following data access.
		if (rd_status) begin
			next_armed = flags; // [RQ2] [RQ4]
		end

		// Transmit side.
		if (tx_xfer) begin
			next_flags[ST_TX_BUFFER_EMPTY] = 1'b1; // [RQ1]
		end
		if (tx_idle) begin
			next_flags[ST_TC] = 1'b1; // [RQ3]
		end

		// Working noise follows the frame in the shifter only.
		if (rx_frame_start) begin
			next_work_noise = rx_noise_event; // [RQ11]
		end else if (rx_noise_event) begin
			next_work_noise = 1'b1; // [RQ11]
		end

		// Consecutive ones on the line.
		if (rx_bit_done) begin
			if (!rx_bit_value) begin
				next_ones_cnt = 4'h0;
			end else if (ones_cnt != ones_limit) begin
				next_ones_cnt = ones_cnt + 4'h1;
			end
		end

		if (rx_active) begin
			if (rx_byte_ready && flags[ST_RX_BUFFER_FULL]) begin
				next_flags[ST_OR] = 1'b1; // [RQ9]
			end
			if (rx_buffer_load) begin
				next_flags[ST_RX_BUFFER_FULL] = 1'b1; // [RQ5]
				next_flags[ST_NF]   = work_noise || rx_noise_event; // [RQ11]
				next_flags[ST_FE]   = !rx_stop_bit; // [RQ13]
				next_idle_allowed   = 1'b1; // [RQ7]
			end
			if (idle_hit && idle_allowed) begin
				next_flags[ST_IDLE] = 1'b1; // [RQ6]
				next_idle_allowed   = 1'b0; // [RQ7]
			end
		end

		// Disabled receiver holds its flags clear.
		if (!receiver_enable) begin
			next_flags[ST_RX_BUFFER_FULL:ST_FE] = 5'h00; // [RQ24]
			next_work_noise           = 1'b0;
		end
		next_flags[0] = 1'b0;
		next_armed[0] = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			flags        <= STATUS_RESET;
			armed        <= 8'h00;
			work_noise   <= 1'b0;
			idle_allowed <= 1'b1;
			ones_cnt     <= 4'h0;
		end else begin
			flags        <= next_flags;
			armed        <= next_armed;
			work_noise   <= next_work_noise;
			idle_allowed <= next_idle_allowed;
			ones_cnt     <= next_ones_cnt;
		end
	end

	assign serial_status_flags = flags;

	// A byte goes out if it replaces an unsent one or follows the arming status read.
	assign tx_accept = !flags[ST_TX_BUFFER_EMPTY] || armed[ST_TX_BUFFER_EMPTY]; // [RQ1] [RQ2]

	// Read data stands for one cycle after the strobe; writes to status are ignored.
	logic [7:0] next_bus_rdata;
	logic [7:0] baud_view;

	assign baud_view = {2'b00, first_stage_ratio_sel, 1'b0, second_stage_ratio_sel}; // [RQ18] [RQ19]

	always_comb begin
		next_bus_rdata = READ_ZERO;
		if (bus_rd) begin
			case (bus_addr)
				ADDR_DATA:   next_bus_rdata = rx_byte;
				ADDR_STATUS: next_bus_rdata = flags; // [RQ25]
				// Test bits always read back as zero.
				ADDR_BAUD: begin
					next_bus_rdata = baud_view;
				end
				default:     next_bus_rdata = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			bus_rdata <= READ_ZERO;
		end else begin
			bus_rdata <= next_bus_rdata;
		end
	end

endmodule

// ### inc/usfbg_pkg.sv
// Constants shared by the serial status-flag and bit-rate generator block.
package usfbg_pkg;

	localparam logic [7:0] ADDR_DATA   = 8'h47;
	localparam logic [7:0] ADDR_STATUS = 8'h4A;
	localparam logic [7:0] ADDR_BAUD   = 8'h4B;

	localparam int unsigned ST_TX_BUFFER_EMPTY = 7;
	localparam int unsigned ST_TC   = 6;
	localparam int unsigned ST_RX_BUFFER_FULL = 5;
	localparam int unsigned ST_IDLE = 4;
	localparam int unsigned ST_OR   = 3;
	localparam int unsigned ST_NF   = 2;
	localparam int unsigned ST_FE   = 1;

	localparam int unsigned BD_DIVIDER_CLEAR_TEST   = 7;
	localparam int unsigned BD_SCP_HI = 5;
	localparam int unsigned BD_SCP_LO = 4;
	localparam int unsigned BD_RX_CLOCK_TEST   = 3;
	localparam int unsigned BD_SCR_HI = 2;
	localparam int unsigned BD_SCR_LO = 0;

	localparam logic [7:0] STATUS_RESET = 8'hC0;
	localparam logic [7:0] BAUD_RESET   = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	localparam logic [3:0] IDLE_ONES_8BIT = 4'hA;
	localparam logic [3:0] IDLE_ONES_9BIT = 4'hB;

	localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
	localparam int unsigned SECOND_STAGE_RATIO_WIDTH     = 7;

	typedef enum logic [1:0] {
		USFBG_RUN  = 2'b01,
		USFBG_STOP = 2'b10
	} usfbg_power_t;

	// Terminal count of the first divider stage: ratio minus one.
	function automatic logic [3:0] usfbg_first_stage_ratio_last(input logic [1:0] sel);
		logic [3:0] last;
		last = 4'h0;
		case (sel)
			2'b00:   last = 4'h0;
			2'b01:   last = 4'h2;
			2'b10:   last = 4'h3;
			2'b11:   last = 4'hC;
			default: last = 4'h0;
		endcase
		return last;
	endfunction

endpackage
